// ===== rtl/dof_filter.sv
// Sample FIFO and display filter core with its Wishbone register slave.
// Assumes samples and the display driver run on clk_i; zero_i is an asynchronous pin.
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dof_fifo #(
  parameter int W = 20,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic push, pop;

  assign push = in_valid_i && rdy_q;
  assign pop = out_ready_i && (cnt_q != '0);

  always_comb begin
    wp_d = push ? ((wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1) : wp_q;
    rp_d = pop ? ((rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    rdy_d = cnt_d != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  assign in_ready_o = rdy_q;
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem_q[rp_q];
  assign count_o = cnt_q;

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

module dof_filter
  import dof_pkg::*;
#(
  parameter int DEPTH = DOF_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Scaled sample stream
  input wire logic smp_valid_i,
  output logic smp_ready_o,
  input wire logic signed [DOF_DW-1:0] smp_data_i,
  // Zero command pin, active high, edge triggered
  input wire logic zero_i,
  // Display value stream
  output dof_disp_t disp_o,
  output logic disp_valid_o,
  input wire logic disp_ready_i
);
  localparam int CW = $clog2(DEPTH) + 1;

  dof_wb_req_t req;
  logic [1:0] lvl_q, lvl_d;
  logic run_q, run_d;
  logic [DOF_BAND_W-1:0] band_q, band_d;
  logic signed [DOF_DW-1:0] ofs_q, ofs_d;
  logic signed [DOF_DW-1:0] raw_q, raw_d;
  dof_disp_t disp_q, disp_d;
  logic dvld_q, dvld_d;
  logic eng_q, eng_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [2:0] zs_q;
  logic zero_pin_evt, zero_sw_evt, zero_evt;
  logic fo_valid, fo_ready;
  logic [DOF_DW-1:0] fo_data;
  logic [CW-1:0] fcnt;
  logic take;
  logic signed [DOF_EW-1:0] corr, diff, absv, filt, shifted;
  logic band_over, band_under;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  dof_fifo #(.W(DOF_DW), .DEPTH(DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(smp_valid_i),
    .in_ready_o(smp_ready_o),
    .in_data_i(smp_data_i),
    .out_valid_o(fo_valid),
    .out_ready_i(fo_ready),
    .out_data_o(fo_data),
    .count_o(fcnt)
  );

  // Zero pin synchroniser; edge taken between second and third stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zs_q <= 3'h0;
    end else begin
      zs_q <= {zs_q[1:0], zero_i};
    end
  end
  assign zero_pin_evt = zs_q[1] && !zs_q[2];
  assign zero_sw_evt = req.cyc && req.stb && req.we && !ack_q && req.sel[0] &&
                       (req.adr == DOF_CMD_OFS) && req.dat[DOF_CMD_ZERO_BIT];
  assign zero_evt = zero_pin_evt || zero_sw_evt;

  // A sample is drained only while running, the display slot is free and no zero is pending
  assign fo_ready = run_q && !zero_evt && (!dvld_q || disp_ready_i);
  assign take = fo_ready && fo_valid;

  // Filter arithmetic
  always_comb begin
    corr = DOF_EW'($signed(fo_data)) + DOF_EW'(ofs_q);
    diff = corr - DOF_EW'(disp_q.value);
    absv = diff[DOF_EW-1] ? -diff : diff;
    band_over = absv > $signed({{(DOF_EW-DOF_BAND_W){1'b0}}, band_q});
    band_under = absv < $signed({{(DOF_EW-DOF_BAND_W){1'b0}}, band_q});
    // Widen the level first so that level 3 shifts by four, not by zero
    shifted = diff >>> ({1'b0, lvl_q} + 3'h1);
    filt = (lvl_q == 2'h0) ? corr : disp_q.value + shifted;
  end

  // Datapath next state
  always_comb begin
    eng_d = eng_q;
    disp_d = disp_q;
    dvld_d = dvld_q && !disp_ready_i;
    raw_d = raw_q;
    // A zero command leaves the engaged state as it was
    if (zero_evt) begin
      disp_d.value = '0;
      disp_d.bypass = 1'b0;
      dvld_d = 1'b1;
    end else if (take) begin
      raw_d = $signed(fo_data);
      if (band_q == '0) begin
        eng_d = 1'b1;
      end else if (band_over) begin
        eng_d = 1'b0;
      end else if (band_under) begin
        eng_d = 1'b1;
      end
      disp_d.value = eng_d ? filt[DOF_DW-1:0] : corr[DOF_DW-1:0];
      disp_d.bypass = !eng_d;
      dvld_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng_q <= 1'b1;
      disp_q <= '0;
      dvld_q <= 1'b0;
      raw_q <= '0;
    end else begin
      eng_q <= eng_d;
      disp_q <= disp_d;
      dvld_q <= dvld_d;
      raw_q <= raw_d;
    end
  end

  // Register slave; one wait state, ack for one cycle, unmapped words read zero
  always_comb begin
    lvl_d = lvl_q;
    run_d = run_q;
    band_d = band_q;
    ofs_d = ofs_q;
    ack_d = req.cyc && req.stb && !ack_q;
    rdat_d = 32'h0000_0000;
    if (ack_d && req.we) begin
      case (req.adr)
        DOF_CTRL_OFS: begin
          if (req.sel[0]) begin
            lvl_d = req.dat[DOF_CTRL_LVL_LSB +: 2];
          end
          if (req.sel[1]) begin
            run_d = req.dat[DOF_CTRL_RUN_BIT];
          end
        end
        DOF_BAND_OFS: begin
          if (req.sel[0]) begin
            band_d = (req.dat[7:0] > DOF_BAND_MAX) ? DOF_BAND_MAX : req.dat[7:0];
          end
        end
        DOF_OFFSET_OFS: begin
          if (req.sel[0]) begin
            ofs_d[7:0] = req.dat[7:0];
          end
          if (req.sel[1]) begin
            ofs_d[15:8] = req.dat[15:8];
          end
          if (req.sel[2]) begin
            ofs_d[DOF_DW-1:16] = req.dat[DOF_DW-1:16];
          end
        end
        default: begin
        end
      endcase
    end else if (ack_d) begin
      case (req.adr)
        DOF_CTRL_OFS: begin
          rdat_d[DOF_CTRL_LVL_LSB +: 2] = lvl_q;
          rdat_d[DOF_CTRL_RUN_BIT] = run_q;
        end
        DOF_BAND_OFS: rdat_d[DOF_BAND_W-1:0] = band_q;
        DOF_OFFSET_OFS: rdat_d = 32'($signed(ofs_q));
        DOF_DISP_OFS: rdat_d = 32'($signed(disp_q.value));
        DOF_STAT_OFS: begin
          rdat_d[DOF_STAT_BYP_BIT] = !eng_q;
          rdat_d[DOF_STAT_CNT_LSB +: CW] = fcnt;
        end
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    if (zero_evt) begin
      ofs_d = -raw_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= DOF_LVL_RST;
      run_q <= DOF_RUN_RST;
      band_q <= DOF_BAND_RST;
      ofs_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      lvl_q <= lvl_d;
      run_q <= run_d;
      band_q <= band_d;
      ofs_q <= ofs_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign disp_o = disp_q;
  assign disp_valid_o = dvld_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  level_zero_pass_a: assert property (take && !zero_evt && lvl_q == 2'h0 |=>
    disp_q.value == $past(corr[DOF_DW-1:0])) else $error("level 0 not passthrough");

  level_one_mix_a: assert property (take && eng_d && lvl_q == 2'h1 |=>
    disp_q.value == $past(DOF_DW'(disp_q.value + (diff >>> 2))))
    else $error("level 1 mix wrong");

  level_two_mix_a: assert property (take && eng_d && lvl_q == 2'h2 |=>
    disp_q.value == $past(DOF_DW'(disp_q.value + (diff >>> 3))))
    else $error("level 2 mix wrong");

  level_three_mix_a: assert property (take && eng_d && lvl_q == 2'h3 |=>
    disp_q.value == $past(DOF_DW'(disp_q.value + (diff >>> 4))))
    else $error("level 3 mix wrong");

  band_bypass_a: assert property (take && band_q != '0 && band_over |=>
    disp_q.bypass && disp_q.value == $past(corr[DOF_DW-1:0]))
    else $error("large step not bypassed");

  band_reengage_a: assert property (take && band_under |=> !disp_q.bypass)
    else $error("small step not filtered");

  band_zero_eng_a: assert property (take && band_q == '0 |=> !disp_q.bypass)
    else $error("band zero bypassed");

  zero_offset_a: assert property (zero_evt |=> ofs_q == -$past(raw_q) &&
    disp_q.value == '0 && disp_valid_o) else $error("zero command mishandled");

  zero_then_show_a: assert property (zero_evt ##1 (take && lvl_q == 2'h0 &&
    fo_data == raw_q) |=> disp_q.value == '0) else $error("zeroed input not shown zero");

  bus_ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o) else $error("ack not a single pulse");

  band_limit_a: assert property (band_q <= DOF_BAND_MAX)
    else $error("band above limit");

  offset_add_a: assert property (take && (!eng_d || lvl_q == 2'h0) |=>
    disp_q.value == $past(DOF_DW'(fo_data + ofs_q))) else $error("offset not added");

  // Display word stands until the driver takes it; a zero may replace it
  disp_hold_a: assert property (disp_valid_o && !disp_ready_i && !zero_evt |=>
    disp_valid_o && $stable(disp_o)) else $error("display value dropped");

  rd_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");

  fifo_full_stop_a: assert property (fcnt == CW'(DEPTH) |-> !smp_ready_o)
    else $error("ready while fifo full");

  bypass_cov: cover property (take && band_over ##[1:20] take && band_under);
  zero_cov: cover property (zero_pin_evt);
  fifo_full_cov: cover property (!smp_ready_o && !disp_ready_i);
  level3_cov: cover property (take && lvl_q == 2'h3 && eng_d);
  zero_take_cov: cover property (zero_evt ##1 take);
endmodule

`default_nettype wire

// ===== rtl/dof_pkg.sv
// Constants, register map and carrier types of the display offset and band filter.
// Assumes a 32-bit classic Wishbone slave port and a 200 MHz single clock.
package dof_pkg;

  // Data widths
  localparam int DOF_DW = 20;
  localparam int DOF_EW = DOF_DW + 2;
  localparam int DOF_BAND_W = 8;
  localparam int DOF_FIFO_DEPTH = 8;

  // Byte offsets of the register words
  localparam logic [7:0] DOF_CTRL_OFS = 8'h00;
  localparam logic [7:0] DOF_BAND_OFS = 8'h04;
  localparam logic [7:0] DOF_OFFSET_OFS = 8'h08;
  localparam logic [7:0] DOF_CMD_OFS = 8'h0c;
  localparam logic [7:0] DOF_DISP_OFS = 8'h10;
  localparam logic [7:0] DOF_STAT_OFS = 8'h14;

  // Field positions
  localparam int DOF_CTRL_LVL_LSB = 0;
  localparam int DOF_CTRL_RUN_BIT = 8;
  localparam int DOF_CMD_ZERO_BIT = 0;
  localparam int DOF_STAT_BYP_BIT = 0;
  localparam int DOF_STAT_CNT_LSB = 4;

  // Reset values and limits
  localparam logic [1:0] DOF_LVL_RST = 2'h0;
  localparam logic DOF_RUN_RST = 1'b1;
  localparam logic [DOF_BAND_W-1:0] DOF_BAND_RST = 8'h00;
  localparam logic [DOF_BAND_W-1:0] DOF_BAND_MAX = 8'hc7;

  // Displayed value as handed to the display driver
  typedef struct packed {
    logic bypass;
    logic signed [DOF_DW-1:0] value;
  } dof_disp_t;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } dof_wb_req_t;

endpackage

// ===== tb/dof_partner.sv
// Sample source and display driver facing the display filter.
// Assumes clk_i is the filter's clock; stall_i holds off the display side.
`timescale 1ns/1ps
`default_nettype none
module dof_partner
  import dof_pkg::*;
(
  // Clock and stall control
  input wire logic clk_i,
  input wire logic stall_i,
  // Sample stream
  output logic smp_valid_o,
  input wire logic smp_ready_i,
  output logic signed [DOF_DW-1:0] smp_data_o,
  // Display stream
  input wire dof_disp_t disp_i,
  input wire logic disp_valid_i,
  output logic disp_ready_o
);
  dof_disp_t got[$];
  initial begin
    smp_valid_o = 1'b0;
    smp_data_o = '0;
  end
  assign disp_ready_o = !stall_i;
  always @(posedge clk_i) begin
    if (disp_valid_i && disp_ready_o) got.push_back(disp_i);
  end
  task send(input logic signed [DOF_DW-1:0] s);
    int n;
    @(posedge clk_i);
    smp_valid_o <= 1'b1;
    smp_data_o <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (smp_ready_i !== 1'b1 && n < 100);
    smp_valid_o <= 1'b0;
    // Released data line shows the inverse so a stale value is never taken
    smp_data_o <= ~s;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the display offset and band filter.
// Assumes dof_partner as the sample source and display driver.
`timescale 1ns/1ps
`default_nettype none
module tb_top import dof_pkg::*;;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, zero = 0, stall = 0;
  logic [3:0] sel = 4'hf;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, wb_dat_o;
  logic wb_ack_o, smp_valid, smp_ready, disp_valid, disp_ready;
  logic signed [DOF_DW-1:0] smp_data, off = 0, dsp = 0, last = 0;
  dof_disp_t disp, expq[$];
  logic eng = 1;
  logic [1:0] lvl = 0;
  logic [15:0] rs = 16'h0022;
  int band = 0, mismatches = 0, checks = 0;
  always #2.5 clk_i = ~clk_i;
  dof_filter #(.DEPTH(DOF_FIFO_DEPTH)) u_dof_filter (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smp_valid_i(smp_valid),
    .smp_ready_o(smp_ready), .smp_data_i(smp_data), .zero_i(zero), .disp_o(disp),
    .disp_valid_o(disp_valid), .disp_ready_i(disp_ready));
  dof_partner u_dof_partner (.clk_i(clk_i), .stall_i(stall), .smp_valid_o(smp_valid),
    .smp_ready_i(smp_ready), .smp_data_o(smp_data), .disp_i(disp),
    .disp_valid_i(disp_valid), .disp_ready_o(disp_ready));
  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task chkd(input dof_disp_t e, input dof_disp_t g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] display exp %h got %h", e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      mismatches++;
      $display("[ERR] bus ack exp 1 got %b", wb_ack_o);
    end
    rd = wb_dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk("register", e, rd);
  endtask
  // Reference filter: predicts the display value, then hands the sample over
  task put(input logic signed [DOF_DW-1:0] s);
    logic signed [DOF_DW-1:0] c, df;
    int ad;
    c = s + off;
    df = c - dsp;
    ad = (df < 0) ? -int'(df) : int'(df);
    if (band == 0) eng = 1;
    else if (ad > band) eng = 0;
    else if (ad < band) eng = 1;
    dsp = (!eng || lvl == 0) ? c : dsp + (df >>> (lvl + 1));
    last = s;
    expq.push_back({!eng, dsp});
    u_dof_partner.send(s);
  endtask
  task putr;
    rs = nx(rs);
    put({{4{rs[15]}}, rs});
  endtask
  task zpred;
    off = -last;
    dsp = 0;
    expq.push_back('0);
  endtask
  task drain;
    int n;
    n = 0;
    while (u_dof_partner.got.size() < expq.size() && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    while (expq.size() > 0 && u_dof_partner.got.size() > 0)
      chkd(expq.pop_front(), u_dof_partner.got.pop_front());
    chk("left over", 0, expq.size() + u_dof_partner.got.size());
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    rdchk(DOF_CTRL_OFS, 32'h100);
    rdchk(DOF_BAND_OFS, 0);
    rdchk(DOF_OFFSET_OFS, 0);
    rdchk(8'h20, 0);
    $display("test reset values done");
    for (int l = 0; l < 4; l++) begin
      wb(1, DOF_CTRL_OFS, 32'h100 | l);
      lvl = 2'(l);
      repeat (6) putr();
      drain();
    end
    $display("test levels done");
    wb(1, DOF_BAND_OFS, 32'hff);
    rdchk(DOF_BAND_OFS, 32'hc7);
    wb(1, DOF_BAND_OFS, 32'ha);
    band = 10;
    put(dsp + 500);
    put(dsp + 3);
    put(dsp + 13);
    put(dsp + 10);
    put(dsp - 200);
    drain();
    rdchk(DOF_DISP_OFS, 32'(dsp));
    wb(0, DOF_STAT_OFS, 0);
    chk("bypass flag", !eng, rd[0]);
    $display("test band done");
    wb(1, DOF_OFFSET_OFS, 32'h5);
    off = 5;
    repeat (3) putr();
    wb(1, DOF_OFFSET_OFS, 0);
    off = 0;
    putr();
    drain();
    $display("test offset done");
    wb(1, DOF_CMD_OFS, 1);
    zpred();
    drain();
    rdchk(DOF_OFFSET_OFS, 32'(off));
    putr();
    drain();
    zero <= 1;
    repeat (6) @(posedge clk_i);
    zero <= 0;
    zpred();
    drain();
    wb(1, DOF_CTRL_OFS, 32'h100);
    lvl = 0;
    // Pin edge lands one cycle before the next sample leaves the FIFO
    zero <= 1;
    zpred();
    put(last);
    repeat (3) @(posedge clk_i);
    zero <= 0;
    drain();
    wb(1, DOF_CTRL_OFS, 32'h000);
    putr();
    repeat (4) @(posedge clk_i);
    wb(0, DOF_STAT_OFS, 0);
    chk("held count", 1, rd[7:4]);
    wb(1, DOF_CTRL_OFS, 32'h100);
    drain();
    $display("test zero done");
    stall <= 1;
    repeat (9) putr();
    repeat (2) @(posedge clk_i);
    chk("sample ready", 0, smp_ready);
    wb(0, DOF_STAT_OFS, 0);
    chk("fifo count", DOF_FIFO_DEPTH, rd[7:4]);
    stall <= 0;
    drain();
    $display("test fifo done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
